// ### include/ibpt_pkg.sv
// Purpose: Shared constants and types for the interleaved boost timing block
// Assumes: 25 MHz system clock
// Notes: Timing counts derive from times in ns and the clock period

package ibpt_pkg;
    localparam int CLK_PERIOD_NS = 40;
    // Default switching period, 100 kHz
    localparam int SW_PERIOD_NS = 10000;
    localparam int SW_PERIOD_CYC = SW_PERIOD_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    // Default start-up delay before drive begins, 1 ms
    localparam int STARTUP_NS = 1000000;
    localparam int STARTUP_CYC = STARTUP_NS / CLK_PERIOD_NS;
    localparam int STARTUP_W = 16;
    // Channel counts selected by load level
    localparam logic [1:0] CH_ONE = 2'h1;
    localparam logic [1:0] CH_TWO = 2'h2;
    localparam logic [1:0] CH_THREE = 2'h3;
    // Load thresholds in percent of full load
    localparam logic [6:0] LOAD_LOW_PCT = 7'h1e;
    localparam logic [6:0] LOAD_MID_PCT = 7'h3c;

    typedef enum logic [1:0] {
        IBPT_ST_INRUSH = 2'b00,
        IBPT_ST_SOFT = 2'b01,
        IBPT_ST_RUN = 2'b11,
        IBPT_ST_FAULT = 2'b10
    } ibpt_state_t;

    typedef struct packed {
        logic ch1_on;
        logic ch1_off;
        logic ch2_on;
        logic ch2_off;
    } ibpt_pulses_t;
endpackage

// ### src/ibpt_timing.sv
// Purpose: Phase timing for an interleaved boost power-factor controller
// Assumes: Master drive is looped back to both sync inputs on the board
// Notes: Slave drives come from external set/reset flip-flops

`timescale 1ns/10ps

module ibpt_timing
    import ibpt_pkg::*;
#(
    parameter int PERIOD_CYC = SW_PERIOD_CYC,
    parameter int STARTUP_CYCLES = STARTUP_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic comparator_hi,
    input wire logic comparator_lo,
    input wire logic sync_rise_input,
    input wire logic sync_fall_input,
    input wire logic enable_in,
    input wire logic line_zero_cross_in,
    input wire logic fault_in,
    input wire logic output_regulated,
    input wire logic [6:0] load_pct,
    output logic sw_clock_out,
    output logic master_phase_drive,
    output logic ch1_on_pulse,
    output logic ch1_off_pulse,
    output logic ch2_on_pulse,
    output logic ch2_off_pulse,
    output logic fault_indicator_n,
    output logic startup_done_n,
    output logic zero_cross_pulse
);
    localparam logic [CNT_W-1:0] PER = CNT_W'(PERIOD_CYC);
    localparam logic [CNT_W-1:0] HALF = CNT_W'(PERIOD_CYC / 2);
    localparam logic [CNT_W-1:0] THIRD = CNT_W'(PERIOD_CYC / 3);
    localparam logic [CNT_W-1:0] TWO_THIRD = CNT_W'((2 * PERIOD_CYC) / 3);
    localparam logic [STARTUP_W-1:0] SU_LAST = STARTUP_W'(STARTUP_CYCLES - 1);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [6:0] meta_reg;
    logic [6:0] sync_reg;
    logic rise_prev_reg, fall_prev_reg, zvd_prev_reg;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= 7'h00;
            sync_reg <= 7'h00;
        end else if (clk_en) begin
            meta_reg <= {comparator_lo, fault_in, line_zero_cross_in,
                         enable_in, sync_fall_input, sync_rise_input,
                         comparator_hi};
            sync_reg <= meta_reg;
        end
    end

    logic cmp_hi_s, cmp_lo_s, rise_s, fall_s, enable_s, zvd_s, fault_s;
    assign {cmp_lo_s, fault_s, zvd_s, enable_s, fall_s, rise_s,
            cmp_hi_s} = sync_reg;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rise_prev_reg <= 1'b0;
            fall_prev_reg <= 1'b0;
            zvd_prev_reg <= 1'b0;
        end else if (clk_en) begin
            rise_prev_reg <= rise_s;
            fall_prev_reg <= fall_s;
            zvd_prev_reg <= zvd_s;
        end
    end

    logic rise_edge, fall_edge;
    assign rise_edge = rise_s && !rise_prev_reg;
    assign fall_edge = !fall_s && fall_prev_reg;

    // ---------------------------------------------------------------
    // Zero crossing
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            zero_cross_pulse <= 1'b0;
        end else if (clk_en) begin
            zero_cross_pulse <= zvd_s && !zvd_prev_reg;
        end
    end

    // ---------------------------------------------------------------
    // Switching timebase
    // ---------------------------------------------------------------
    logic [CNT_W-1:0] tb_cnt_reg;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tb_cnt_reg <= '0;
        end else if (clk_en) begin
            tb_cnt_reg <= (tb_cnt_reg == PER - 1'b1) ? '0 : tb_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sw_clock_out <= 1'b0;
        end else if (clk_en) begin
            sw_clock_out <= (tb_cnt_reg < HALF);
        end
    end

    // ---------------------------------------------------------------
    // Start-up and fault sequencing
    // ---------------------------------------------------------------
    ibpt_state_t state_reg;
    logic [STARTUP_W-1:0] su_cnt_reg;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= IBPT_ST_INRUSH;
        end else if (clk_en) begin
            case (state_reg)
                IBPT_ST_INRUSH: begin
                    if (fault_s) begin
                        state_reg <= IBPT_ST_FAULT;
                    end else if (su_cnt_reg == SU_LAST) begin
                        state_reg <= IBPT_ST_SOFT;
                    end
                end
                IBPT_ST_SOFT: begin
                    if (fault_s) begin
                        state_reg <= IBPT_ST_FAULT;
                    end else if (output_regulated) begin
                        state_reg <= IBPT_ST_RUN;
                    end
                end
                IBPT_ST_RUN: begin
                    if (fault_s) begin
                        state_reg <= IBPT_ST_FAULT;
                    end
                end
                IBPT_ST_FAULT: begin
                    // Restart through the soft power-on once clear
                    if (!fault_s) begin
                        state_reg <= IBPT_ST_SOFT;
                    end
                end
                default: begin
                    state_reg <= IBPT_ST_FAULT;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            su_cnt_reg <= '0;
        end else if (clk_en && state_reg == IBPT_ST_INRUSH) begin
            su_cnt_reg <= su_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_indicator_n <= 1'b1;
            startup_done_n <= 1'b1;
        end else if (clk_en) begin
            fault_indicator_n <= !fault_s;
            startup_done_n <= !(state_reg == IBPT_ST_RUN && !fault_s);
        end
    end

    // ---------------------------------------------------------------
    // Master drive
    // ---------------------------------------------------------------
    logic running;
    assign running = (state_reg == IBPT_ST_SOFT || state_reg == IBPT_ST_RUN);

    // Turn-on only while the enable clock is high, so noise on the
    // comparators in the low half cannot start a second pulse
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            master_phase_drive <= 1'b0;
        end else if (clk_en) begin
            if (!running || fault_s) begin
                master_phase_drive <= 1'b0;
            end else if (!master_phase_drive) begin
                master_phase_drive <= cmp_hi_s && enable_s;
            end else begin
                master_phase_drive <= cmp_lo_s;
            end
        end
    end

    // ---------------------------------------------------------------
    // Channel count by load
    // ---------------------------------------------------------------
    logic [1:0] ch_count_reg;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ch_count_reg <= CH_ONE;
        end else if (clk_en) begin
            if (load_pct < LOAD_LOW_PCT) begin
                ch_count_reg <= CH_ONE;
            end else if (load_pct < LOAD_MID_PCT) begin
                ch_count_reg <= CH_TWO;
            end else begin
                ch_count_reg <= CH_THREE;
            end
        end
    end

    // ---------------------------------------------------------------
    // Phase delay counters
    // ---------------------------------------------------------------
    // Index 0 counts from turn-on, index 1 from turn-off
    logic [1:0] trig;
    assign trig = {fall_edge, rise_edge};
    logic [CNT_W-1:0] ph_cnt_reg [2];
    logic [1:0] ph_act_reg;
    logic [CNT_W-1:0] delay_a;
    // Delays use the nominal period; a slow master only shifts phase
    assign delay_a = (ch_count_reg == CH_THREE) ? THIRD : HALF;
    logic [1:0] hit_a, hit_b;
    ibpt_pulses_t pulses_next;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_phase
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    ph_cnt_reg[g] <= '0;
                    ph_act_reg[g] <= 1'b0;
                end else if (clk_en) begin
                    if (trig[g]) begin
                        ph_cnt_reg[g] <= '0;
                        ph_act_reg[g] <= 1'b1;
                    end else if (ph_act_reg[g]) begin
                        ph_cnt_reg[g] <= ph_cnt_reg[g] + 1'b1;
                        if (ph_cnt_reg[g] == PER - 1'b1) begin
                            ph_act_reg[g] <= 1'b0;
                        end
                    end
                end
            end
            assign hit_a[g] = ph_act_reg[g] && !trig[g] &&
                              ph_cnt_reg[g] + 1'b1 == delay_a;
            assign hit_b[g] = ph_act_reg[g] && !trig[g] &&
                              ph_cnt_reg[g] + 1'b1 == TWO_THIRD;
        end
    endgenerate

    always_comb begin
        pulses_next.ch1_on = hit_a[0] && ch_count_reg != CH_ONE &&
                             !fault_s;
        pulses_next.ch1_off = hit_a[1] && ch_count_reg != CH_ONE;
        pulses_next.ch2_on = hit_b[0] && ch_count_reg == CH_THREE &&
                             !fault_s;
        pulses_next.ch2_off = hit_b[1] && ch_count_reg == CH_THREE;
    end

    // One-cycle pulses to the external set/reset flip-flops
    ibpt_pulses_t pulses_reg;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pulses_reg <= '0;
        end else if (clk_en) begin
            pulses_reg <= pulses_next;
        end else begin
            // Pulses stay one cycle wide even when frozen
            pulses_reg <= '0;
        end
    end
    assign ch1_on_pulse = pulses_reg.ch1_on;
    assign ch1_off_pulse = pulses_reg.ch1_off;
    assign ch2_on_pulse = pulses_reg.ch2_on;
    assign ch2_off_pulse = pulses_reg.ch2_off;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sq_duty_a: assert property (clk_en && tb_cnt_reg == '0 |=> sw_clock_out)
        else $error("square wave not high at period start");
    sq_low_a: assert property (clk_en && tb_cnt_reg == HALF |=> !sw_clock_out)
        else $error("square wave not low in second half");
    fault_pin_a: assert property (clk_en && fault_s |=> !fault_indicator_n)
        else $error("fault pin not low on fault");
    ok_pin_a: assert property (!startup_done_n |-> $past(state_reg) == IBPT_ST_RUN)
        else $error("start-up pin low outside run");
    drive_off_a: assert property (clk_en && fault_s |=> !master_phase_drive)
        else $error("master drive active in fault");
    set_block_a: assert property (fault_s && $past(fault_s) |-> !ch1_on_pulse && !ch2_on_pulse)
        else $error("set pulse during fault");
    pulse_width_a: assert property (ch1_on_pulse |=> !ch1_on_pulse)
        else $error("set pulse wider than one cycle");
    rise_start_a: assert property (clk_en && rise_edge |=> ph_act_reg[0] && ph_cnt_reg[0] == '0)
        else $error("turn-on timing not started");
    fall_start_a: assert property (clk_en && fall_edge |=> ph_act_reg[1] && ph_cnt_reg[1] == '0)
        else $error("turn-off timing not started");
    ch2_phase_a: assert property (ch2_on_pulse |-> $past(ph_cnt_reg[0]) == TWO_THIRD - 1'b1)
        else $error("channel b on pulse at wrong phase");
    ch2_off_a: assert property (ch2_off_pulse |-> $past(ph_cnt_reg[1]) == TWO_THIRD - 1'b1)
        else $error("channel b off pulse at wrong phase");
    ch1_phase_a: assert property (ch1_on_pulse |-> $past(ph_cnt_reg[0]) + 1'b1 == $past(delay_a))
        else $error("channel a on pulse at wrong phase");
    ch1_off_a: assert property (ch1_off_pulse |-> $past(ph_cnt_reg[1]) + 1'b1 == $past(delay_a))
        else $error("channel a off pulse at wrong phase");
    guard_on_a: assert property (clk_en && !master_phase_drive && !enable_s |=> !master_phase_drive)
        else $error("master turned on outside enable window");

    run_c: cover property (state_reg == IBPT_ST_RUN);
    ch1_c: cover property (ch1_on_pulse);
    ch2_c: cover property (ch2_off_pulse);
    fault_c: cover property (state_reg == IBPT_ST_FAULT);
endmodule

// ### test/ibpt_slave_ff.sv
// Purpose: Set/reset flip-flop standing for one slave channel drive
// Assumes: One-cycle set and clear pulses from the timing block
// Notes: Clear wins a tie so a channel never sticks on

`timescale 1ns/10ps

module ibpt_slave_ff (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic set_pulse,
    input wire logic clr_pulse,
    output logic drive
);
    // ----------------------------------------
    // Channel drive latch
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            drive <= 1'b0;
        end else if (clr_pulse) begin
            drive <= 1'b0;
        end else if (set_pulse) begin
            drive <= 1'b1;
        end
    end
endmodule

// ### test/ibpt_timing_tb_top.sv
// Purpose: Self-checking bench for the phase timing block
// Assumes: Short period and start-up counts keep the run brief
// Notes: Sync inputs come from the bench or from the master loop

`timescale 1ns/10ps

module ibpt_timing_tb_top;
    import ibpt_pkg::*;
    // ----------------------------------------
    // Signals and design
    // ----------------------------------------
    localparam int P = 12;
    localparam int SU = 8;
    logic sys_clk, reset_n, clk_en, comparator_hi, comparator_lo;
    logic rise_drv, fall_drv, en_drv, loop_en, fault_in;
    logic line_zero_cross_in, output_regulated;
    logic [6:0] load_pct;
    logic sync_rise_input, sync_fall_input, enable_in;
    logic sw_clock_out, master_phase_drive, fault_indicator_n;
    logic startup_done_n, zero_cross_pulse, drive_a, drive_b, hold_v;
    logic ch1_on_pulse, ch1_off_pulse, ch2_on_pulse, ch2_off_pulse;
    ibpt_pulses_t pv;
    int error_cnt, check_count, cyc, zc_n, hi_n;
    int pn [4];
    int pt [4];
    int lds [6] = '{10, 29, 30, 59, 60, 100};

    // Board loop lets the real master edges drive the slaves
    assign sync_rise_input = loop_en ? master_phase_drive : rise_drv;
    assign sync_fall_input = loop_en ? master_phase_drive : fall_drv;
    assign enable_in = loop_en ? sw_clock_out : en_drv;
    assign pv = {ch1_on_pulse, ch1_off_pulse, ch2_on_pulse, ch2_off_pulse};

    ibpt_timing #(.PERIOD_CYC(P), .STARTUP_CYCLES(SU)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
        .comparator_hi(comparator_hi), .comparator_lo(comparator_lo),
        .sync_rise_input(sync_rise_input),
        .sync_fall_input(sync_fall_input), .enable_in(enable_in),
        .line_zero_cross_in(line_zero_cross_in), .fault_in(fault_in),
        .output_regulated(output_regulated), .load_pct(load_pct),
        .sw_clock_out(sw_clock_out), .master_phase_drive(master_phase_drive),
        .ch1_on_pulse(ch1_on_pulse), .ch1_off_pulse(ch1_off_pulse),
        .ch2_on_pulse(ch2_on_pulse), .ch2_off_pulse(ch2_off_pulse),
        .fault_indicator_n(fault_indicator_n),
        .startup_done_n(startup_done_n), .zero_cross_pulse(zero_cross_pulse)
    );
    ibpt_slave_ff ff_a_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .set_pulse(ch1_on_pulse), .clr_pulse(ch1_off_pulse), .drive(drive_a));
    ibpt_slave_ff ff_b_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .set_pulse(ch2_on_pulse), .clr_pulse(ch2_off_pulse), .drive(drive_b));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc++;
    // Outputs settle by the falling edge, so sample there
    always @(negedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (pv[i] === 1'b1) begin
                if (pn[i] == 0) pt[i] = cyc;
                pn[i]++;
            end
        end
        if (zero_cross_pulse === 1'b1) zc_n++;
        if (sw_clock_out === 1'b1) hi_n++;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            error_cnt++;
            $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic sync_pt;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic clr;
        sync_pt;
        zc_n = 0;
        hi_n = 0;
        foreach (pn[i]) pn[i] = 0;
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim);
        int k;
        k = 0;
        while (s !== v && k < lim) begin
            @(negedge sys_clk);
            k++;
        end
        chk_bit(s, v);
    endtask
    function automatic int nch(input int ld);
        if (ld < int'(LOAD_LOW_PCT)) return 1;
        if (ld < int'(LOAD_MID_PCT)) return 2;
        return 3;
    endfunction
    // Active edge on the chosen sync input only
    task automatic put(input bit fall, input logic v);
        if (fall) fall_drv = ~v;
        else rise_drv = v;
    endtask
    task automatic edge_test(input int ld, input bit fall, input int gap,
                             input bit blk);
        int n, d1, d2, a, b, t0, lat;
        n = blk ? 1 : nch(ld);
        d1 = (n == 3) ? P / 3 : P / 2;
        d2 = 2 * P / 3;
        a = fall ? 2 : 3;
        b = fall ? 0 : 1;
        @(negedge sys_clk);
        load_pct = 7'(ld);
        repeat (P) @(negedge sys_clk);
        clr;
        @(negedge sys_clk);
        put(fall, 1'b1);
        if (gap > 0) begin
            repeat (gap) @(negedge sys_clk);
            put(fall, 1'b0);
            @(negedge sys_clk);
            put(fall, 1'b1);
        end
        t0 = cyc;
        repeat (2 * P) @(negedge sys_clk);
        sync_pt;
        chk(pn[a], int'(n >= 2));
        chk(pn[b], int'(n == 3));
        chk(pn[a ^ 1] + pn[b ^ 1], 0);
        lat = pt[a] - t0;
        if (n >= 2) chk_bit(lat >= 3 + d1 && lat <= 5 + d1, 1'b1);
        if (n == 3) chk(pt[b] - pt[a], d2 - d1);
        @(negedge sys_clk);
        put(fall, 1'b0);
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        summarize;
    end

    initial begin
        void'($urandom(90));
        reset_n = 1'b0;
        clk_en = 1'b1;
        comparator_hi = 1'b0;
        comparator_lo = 1'b0;
        rise_drv = 1'b0;
        fall_drv = 1'b1;
        en_drv = 1'b0;
        loop_en = 1'b0;
        line_zero_cross_in = 1'b0;
        fault_in = 1'b0;
        output_regulated = 1'b1;
        load_pct = 7'h00;
        repeat (10) @(negedge sys_clk);
        chk_bit(fault_indicator_n, 1'b1);
        chk_bit(startup_done_n, 1'b1);
        chk_bit(master_phase_drive, 1'b0);
        reset_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk_bit(startup_done_n, 1'b1);
        wait_for(startup_done_n, 1'b0, SU + 40);
        clr;
        repeat (2 * P) @(negedge sys_clk);
        sync_pt;
        chk(hi_n, P);
        foreach (lds[i]) begin
            edge_test(lds[i], 1'b0, 0, 1'b0);
            edge_test(lds[i], 1'b1, 0, 1'b0);
        end
        edge_test(80, 1'b0, 2, 1'b0);
        edge_test(45, 1'b1, 3, 1'b0);
        repeat (4) begin
            edge_test($urandom_range(100), 1'($urandom_range(1)), 0, 1'b0);
        end
        // Enable held low must block master turn-on
        @(negedge sys_clk);
        // Three channels, so both slave drives must follow
        load_pct = 7'h50;
        comparator_hi = 1'b1;
        comparator_lo = 1'b1;
        repeat (2 * P) @(negedge sys_clk);
        chk_bit(master_phase_drive, 1'b0);
        loop_en = 1'b1;
        wait_for(master_phase_drive, 1'b1, P + 8);
        comparator_hi = 1'b0;
        repeat (2 * P) @(negedge sys_clk);
        chk_bit(drive_a, 1'b1);
        chk_bit(drive_b, 1'b1);
        comparator_lo = 1'b0;
        wait_for(master_phase_drive, 1'b0, 8);
        repeat (2 * P) @(negedge sys_clk);
        chk_bit(drive_a, 1'b0);
        chk_bit(drive_b, 1'b0);
        fault_in = 1'b1;
        wait_for(fault_indicator_n, 1'b0, 8);
        chk_bit(startup_done_n, 1'b1);
        comparator_hi = 1'b1;
        comparator_lo = 1'b1;
        repeat (2 * P) @(negedge sys_clk);
        chk_bit(master_phase_drive, 1'b0);
        loop_en = 1'b0;
        comparator_hi = 1'b0;
        comparator_lo = 1'b0;
        edge_test(80, 1'b0, 0, 1'b1);
        fault_in = 1'b0;
        wait_for(fault_indicator_n, 1'b1, 8);
        wait_for(startup_done_n, 1'b0, SU + 40);
        clr;
        @(negedge sys_clk);
        line_zero_cross_in = 1'b1;
        repeat (8) @(negedge sys_clk);
        line_zero_cross_in = 1'b0;
        repeat (8) @(negedge sys_clk);
        sync_pt;
        chk(zc_n, 1);
        // Low clock enable freezes the timebase
        @(negedge sys_clk);
        clk_en = 1'b0;
        @(negedge sys_clk);
        hold_v = sw_clock_out;
        repeat (P / 2) @(negedge sys_clk);
        chk_bit(sw_clock_out, hold_v);
        clk_en = 1'b1;
        summarize;
    end
endmodule
